// ==== rtl/clkpll_map.svh ====
// Register offsets, field positions and reset values of the clock and strap block.
`ifndef CLKPLL_MAP_SVH
`define CLKPLL_MAP_SVH
`define CTRL_OFS 2'h0
`define STAT_OFS 2'h1
`define ADR_WORD_MSB 3
`define ADR_WORD_LSB 2
`define CTRL_PEN_BIT 0
`define CTRL_MF_LSB 4
`define CTRL_MF_MSB 7
`define CTRL_DF_LSB 8
`define CTRL_DF_MSB 11
`define FACTOR_ONE 4'h1
`define STAT_NMI_BIT 0
`define STAT_CORE_BIT 1
`define STAT_EXT_BIT 2
`define STAT_PEN_BIT 3
`endif

// ==== rtl/clkpll_pkg.sv ====
// Types shared by the clock output and strap block.
package clkpll_pkg;
  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } wb_req_type;

  typedef struct packed {
    logic [31:0] dat;
    logic ack;
  } wb_rsp_type;

  typedef enum logic [1:0] {
    CLK_DIV2 = 2'b00,
    CLK_BYPASS = 2'b01,
    CLK_LOCKED = 2'b10
  } clk_mode_type;

  typedef struct packed {
    logic pll_enable_bit;
    logic [3:0] mf;
    logic [3:0] df;
    logic ext_prev;
    logic div;
    logic core;
    logic nmi_samp;
    logic nmi_pend;
    logic nmi_req;
    logic ack;
    logic [31:0] rdat;
  } clk_state_type;
endpackage

// ==== rtl/sync_two.sv ====
// Two-flop synchroniser for a pin level entering the clk_i domain.
module sync_two (
  // Clock
  input wire logic clk_i,
  // Level
  input wire logic d_i,
  output logic q_o
);
  logic meta_q;
  logic stable_q;

  // No reset, so the strap level is already settled while reset is held.
  always_ff @(posedge clk_i) begin
    meta_q <= d_i;
    stable_q <= meta_q;
  end

  assign q_o = stable_q;
endmodule

// ==== rtl/core_clock_output.sv ====
// Clock output generation, PLL enable strap capture and NMI edge detection.
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`include "clkpll_map.svh"

// What this block does
// - The clock output is always phase-aligned to the internal core clock.
// - With the PLL on and both factors equal to one the clock output also follows the input clock.
// - With the PLL off the clock output runs at exactly half the input clock frequency.
// - While reset is held the strap level is copied into the PLL enable bit.
// - After reset the shared pin is a falling-edge NMI request sampled on the clock output.
// - The clock output pin stays actively driven during reset.
module core_clock_output (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire clkpll_pkg::wb_req_type wb_req_i,
  output clkpll_pkg::wb_rsp_type wb_rsp_o,
  // Pins
  input wire logic ext_clock_in_i,
  input wire logic strap_nmi_i,
  output logic crystal_drive_out_o,
  output logic core_clock_out_o,
  output logic core_clock_out_oe_o,
  // Core side
  output logic core_clock_o,
  output logic nmi_req_o,
  output clkpll_pkg::clk_mode_type clk_mode_o
);
  import clkpll_pkg::*;

  clk_state_type s_q;
  clk_state_type s_d;
  logic ext_s;
  logic strap_s;
  logic ext_rise;
  logic core_rise;
  logic nmi_fall;
  logic bus_hit;
  logic bus_wr;
  clk_mode_type mode;

  // Both pins are asynchronous to clk_i, so each passes two flops before any logic reads it.
  sync_two u_ext_sync (
    .clk_i(clk_i),
    .d_i(ext_clock_in_i),
    .q_o(ext_s)
  );

  sync_two u_strap_sync (
    .clk_i(clk_i),
    .d_i(strap_nmi_i),
    .q_o(strap_s)
  );

  function automatic logic factors_one(input logic [3:0] mf, input logic [3:0] df);
    factors_one = (mf == `FACTOR_ONE) && (df == `FACTOR_ONE);
  endfunction

  always_comb begin
    s_d = s_q;
    // The analog loop is not modelled, so a locked PLL also tracks the input phase.
    if (!s_q.pll_enable_bit) begin
      mode = CLK_DIV2;
    end else if (factors_one(s_q.mf, s_q.df)) begin
      mode = CLK_BYPASS;
    end else begin
      mode = CLK_LOCKED;
    end
    ext_rise = ext_s & ~s_q.ext_prev;
    bus_hit = wb_req_i.cyc & wb_req_i.stb;
    bus_wr = bus_hit & wb_req_i.we & s_q.ack;
    s_d.ext_prev = ext_s;
    if (ext_rise) begin
      s_d.div = ~s_q.div;
    end
    s_d.core = (mode == CLK_DIV2) ? s_q.div : ext_s;
    core_rise = s_d.core & ~s_q.core;
    nmi_fall = core_rise & s_q.nmi_samp & ~strap_s;
    s_d.nmi_req = nmi_fall;
    if (core_rise) begin
      s_d.nmi_samp = strap_s;
    end
    // Ack lasts one cycle; a master that keeps its strobe up is simply answered again.
    s_d.ack = bus_hit & ~s_q.ack;
    s_d.rdat = '0;
    if (bus_hit && !s_q.ack && !wb_req_i.we) begin
      case (wb_req_i.adr[`ADR_WORD_MSB:`ADR_WORD_LSB])
        `CTRL_OFS: begin
          s_d.rdat[`CTRL_PEN_BIT] = s_q.pll_enable_bit;
          s_d.rdat[`CTRL_MF_MSB:`CTRL_MF_LSB] = s_q.mf;
          s_d.rdat[`CTRL_DF_MSB:`CTRL_DF_LSB] = s_q.df;
        end
        `STAT_OFS: begin
          s_d.rdat[`STAT_NMI_BIT] = s_q.nmi_pend;
          s_d.rdat[`STAT_CORE_BIT] = s_q.core;
          s_d.rdat[`STAT_EXT_BIT] = ext_s;
          s_d.rdat[`STAT_PEN_BIT] = s_q.pll_enable_bit;
        end
        default: begin
          s_d.rdat = '0;
        end
      endcase
    end
    if (bus_wr && wb_req_i.adr[`ADR_WORD_MSB:`ADR_WORD_LSB] == `CTRL_OFS) begin
      if (wb_req_i.sel[0]) begin
        s_d.pll_enable_bit = wb_req_i.dat[`CTRL_PEN_BIT];
        s_d.mf = wb_req_i.dat[`CTRL_MF_MSB:`CTRL_MF_LSB];
      end
      if (wb_req_i.sel[1]) begin
        s_d.df = wb_req_i.dat[`CTRL_DF_MSB:`CTRL_DF_LSB];
      end
    end
    // A new edge in the clearing cycle keeps the flag set.
    if (bus_wr && wb_req_i.adr[`ADR_WORD_MSB:`ADR_WORD_LSB] == `STAT_OFS && wb_req_i.sel[0]
        && wb_req_i.dat[`STAT_NMI_BIT]) begin
      s_d.nmi_pend = 1'b0;
    end
    if (nmi_fall) begin
      s_d.nmi_pend = 1'b1;
    end
    if (rst_i) begin
      s_d = '0;
      s_d.pll_enable_bit = strap_s;
      s_d.mf = `FACTOR_ONE;
      s_d.df = `FACTOR_ONE;
      s_d.ext_prev = ext_s;
      // Tracking the pin level keeps a strap held low from looking like an edge after reset.
      s_d.nmi_samp = strap_s;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign core_clock_out_o = s_q.core;
  assign core_clock_o = s_q.core;
  assign core_clock_out_oe_o = 1'b1;
  assign crystal_drive_out_o = ~s_q.ext_prev;
  assign nmi_req_o = s_q.nmi_req;
  assign wb_rsp_o.ack = s_q.ack;
  assign wb_rsp_o.dat = s_q.rdat;
  assign clk_mode_o = mode;

  // The pin register is the core clock itself, so it must carry last cycle's selected source.
  property p_core_aligned;
    @(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |-> (core_clock_out_o == $past((mode == CLK_DIV2) ? s_q.div : ext_s));
  endproperty
  a_core_aligned: assert property (p_core_aligned)
    else $error("clock output off core phase");

  property p_bypass_follow;
    @(posedge clk_i) disable iff (rst_i)
      (s_q.pll_enable_bit && factors_one(s_q.mf, s_q.df)) |=> (core_clock_out_o == $past(ext_s));
  endproperty
  a_bypass_follow: assert property (p_bypass_follow)
    else $error("bypass clock not following input");

  property p_bypass_mode;
    @(posedge clk_i) disable iff (rst_i)
      (s_q.pll_enable_bit && factors_one(s_q.mf, s_q.df)) |-> (clk_mode_o == CLK_BYPASS);
  endproperty
  a_bypass_mode: assert property (p_bypass_mode)
    else $error("unity factors not in bypass mode");

  sequence s_ext_rise;
    ext_s && !s_q.ext_prev;
  endsequence

  property p_half_rate;
    @(posedge clk_i) disable iff (rst_i)
      (!s_q.pll_enable_bit && !$past(rst_i)) ##0 s_ext_rise |=> (s_q.div != $past(s_q.div));
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("divider missed input edge");

  property p_div_hold;
    @(posedge clk_i) disable iff (rst_i) !(ext_s && !s_q.ext_prev) |=> $stable(s_q.div);
  endproperty
  a_div_hold: assert property (p_div_hold)
    else $error("divider toggled without input edge");

  property p_off_mode;
    @(posedge clk_i) disable iff (rst_i) !s_q.pll_enable_bit |-> (clk_mode_o == CLK_DIV2);
  endproperty
  a_off_mode: assert property (p_off_mode)
    else $error("pll off but not in divide mode");

  // A mode change lands on one edge and reaches the pin on the next, hence the look back.
  property p_div_drives_pin;
    @(posedge clk_i) disable iff (rst_i)
      (!$past(rst_i) && !$past(s_q.pll_enable_bit)) |-> (core_clock_out_o == $past(s_q.div));
  endproperty
  a_div_drives_pin: assert property (p_div_drives_pin)
    else $error("clock output not carrying divider");

  // The strap needs two flops, so the copy is judged only after three reset edges.
  sequence s_reset_held;
    rst_i [*3];
  endsequence

  property p_strap_copy;
    @(posedge clk_i) s_reset_held |=> (s_q.pll_enable_bit == $past(strap_s));
  endproperty
  a_strap_copy: assert property (p_strap_copy)
    else $error("enable bit not copied from strap");

  property p_nmi_set;
    @(posedge clk_i) disable iff (rst_i) nmi_req_o |-> s_q.nmi_pend ##1 $fell(nmi_req_o);
  endproperty
  a_nmi_set: assert property (p_nmi_set) else $error("nmi pulse without pending flag");

  property p_nmi_needs_low;
    @(posedge clk_i) disable iff (rst_i) nmi_req_o |-> !$past(strap_s);
  endproperty
  a_nmi_needs_low: assert property (p_nmi_needs_low)
    else $error("nmi raised while pin was high");

  property p_nmi_on_core_edge;
    @(posedge clk_i) disable iff (rst_i) $rose(nmi_req_o) |-> $rose(s_q.core);
  endproperty
  a_nmi_on_core_edge: assert property (p_nmi_on_core_edge)
    else $error("nmi not on core edge");

  property p_driven_in_reset;
    @(posedge clk_i) rst_i |-> core_clock_out_oe_o ##1 core_clock_out_oe_o;
  endproperty
  a_driven_in_reset: assert property (p_driven_in_reset)
    else $error("clock pin released");
endmodule

// ==== verification/ext_source.sv ====
// Free-running external clock source model for the oscillator input.
module ext_source #(parameter int HALF = 4) (
  // Clock
  input wire logic clk_i,
  // Pin
  output logic ext_clock_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial ext_clock_o = 1'b0;
  always @(posedge clk_i) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) ext_clock_o <= ~ext_clock_o;
  end
endmodule

// ==== verification/core_clock_output_and_pll_strap_bench.sv ====
// Self-checking bench for the clock output and strap block.
module core_clock_output_and_pll_strap_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import clkpll_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic strap = 1'b1;
  logic ext, cko, oe, core, nmi, xd;
  wb_req_type req = '0;
  wb_rsp_type rsp;
  clk_mode_type mode;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] rd;
  always #20 clk_i = ~clk_i;
  ext_source i_src (.clk_i(clk_i), .ext_clock_o(ext));
  core_clock_output i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .ext_clock_in_i(ext), .strap_nmi_i(strap), .crystal_drive_out_o(xd), .core_clock_out_o(cko),
    .core_clock_out_oe_o(oe), .core_clock_o(core), .nmi_req_o(nmi), .clk_mode_o(mode));
  task automatic test_done;
    if (fails == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // The request stands until the edge that samples ack high; only the run timeout ends a wait.
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    req <= '{adr: a, dat: d, sel: 4'hf, we: w, cyc: 1'b1, stb: 1'b1};
    do begin
      @(posedge clk_i);
    end while (rsp.ack !== 1'b1);
    rd = rsp.dat;
    req <= '0;
    @(posedge clk_i);
    chk(32'(rsp.ack), 32'h0);
  endtask
  task automatic do_reset(input logic s);
    rst_i <= 1'b1;
    strap <= s;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk(32'(oe), 32'h1);
    chk(32'(cko), 32'h0);
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    wb(1'b0, 32'h4, 32'h0);
    chk(32'(rd[3]), 32'(s));
    wb(1'b0, 32'h0, 32'h0);
    chk({23'h0, rd[11:4], rd[0]}, {23'h0, 8'h11, s});
    repeat (40) @(posedge clk_i);
    wb(1'b0, 32'h4, 32'h0);
    chk(32'(rd[0]), 32'h0);
  endtask
  task automatic rates(input logic [31:0] ctl, input clk_mode_type m, input int div);
    int e, c, x;
    logic pe, pc, px;
    e = 0;
    c = 0;
    x = 0;
    wb(1'b1, 32'h0, ctl);
    repeat (8) @(posedge clk_i);
    pe = ext;
    pc = cko;
    px = xd;
    repeat (192) begin
      @(negedge clk_i);
      e += int'(ext & ~pe);
      c += int'(cko & ~pc);
      x += int'(~xd & px);
      pe = ext;
      pc = cko;
      px = xd;
      chk(32'(core), 32'(cko));
    end
    chk(32'(x >= e - 1 && x <= e + 1), 32'h1);
    chk(32'(mode), 32'(m));
    chk(32'(c * div >= e - div && c * div <= e + div), 32'h1);
    @(posedge clk_i);
  endtask
  task automatic nmi_edge;
    int p;
    p = 0;
    strap <= 1'b0;
    repeat (100) begin
      @(negedge clk_i);
      p += int'(nmi);
    end
    chk(32'(p), 32'h1);
    @(posedge clk_i);
    wb(1'b0, 32'h4, 32'h0);
    chk(32'(rd[0]), 32'h1);
    wb(1'b1, 32'h4, 32'h1);
    wb(1'b0, 32'h4, 32'h0);
    chk(32'(rd[0]), 32'h0);
  endtask
  initial begin
    do_reset(1'b1);
    rates(32'h110, CLK_DIV2, 2);
    rates(32'h111, CLK_BYPASS, 1);
    rates(32'h121, CLK_LOCKED, 1);
    nmi_edge;
    wb(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h0);
    do_reset(1'b0);
    test_done;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      test_done;
    end
  end
endmodule
